// ==== design/mmm_memory_map.sv ====
// Purpose: scratchpad RAM, core SFRs, bit access, stack and program/xdata decode
// Assumes: core issues one access per cycle and holds address/data for that cycle
// Notes: read data is registered, one cycle after the request
// What this block does
// - flash data lives in external data space, writes steered by write select
// - only lowest 64 system memory bytes writable, and only in programming mode
// - direct addresses 80h-FFh always decode to special function registers
// - direct addresses 00h-7Fh reach lower scratchpad RAM
// - upper 128 RAM bytes are reached only by indirect addressing
// - bytes 20h-2Fh give 128 single-bit locations
// - SFR bit access only where address low nibble is 0h or 8h
// - bit versus byte access chosen by access type, not address
// - four banks of eight working registers, bank chosen by status word
// - stack pointer at 81h resets to 07h and is writable
// - push/call pre-increment then store; pop/return read then decrement
// - first fetch after reset is from 0000h
// - boot ROM enabled maps F800h-FFFFh to boot ROM not flash
// - in user mode boot routines sit at F800h-FBFFh
// - write select register at 8Fh picks data or program flash target
// - undefined SFR reads return zero
// - partitioned data flash begins at external address 0400h
`timescale 1ns/1ns
module mmm_memory_map #(
    parameter int RAM_DEPTH = 256
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // register-space access from the core
    input wire mmm_pkg::mmm_acc_t accType,
    input wire logic [7:0] accAddr,
    input wire logic accWrite,
    input wire logic [7:0] accWdata,
    input wire logic accBitVal,
    output logic [7:0] accRdata,
    output logic accRbit,
    output logic sfrExternal,
    // program space decode
    input wire logic [15:0] progAddr,
    input wire logic bootRomEn,
    input wire logic progModeSerial,
    output logic progToBoot,
    output logic progBootUser,
    output logic [15:0] resetVector,
    // external data space decode
    input wire logic [15:0] xdataAddr,
    input wire logic xdataWrite,
    input wire logic dataFlashPartitioned,
    output logic xdataToDataFlash,
    output logic xdataWriteProgram,
    output logic xdataWriteData,
    // system memory write gate
    input wire logic [7:0] sysMemAddr,
    input wire logic sysMemWrite,
    output logic sysMemWriteOk,
    // status word bank bits and stack pointer seen by the core
    output logic [1:0] bankSel,
    output logic [7:0] stackPtr
);
    import mmm_pkg::*;

    logic rstSync1_q;
    logic rstSync2_q;
    logic [7:0] ram_q [RAM_DEPTH];
    logic [7:0] stackPtr_q;
    logic [7:0] stackPtr_d;
    logic [7:0] writeSel_q;
    logic [7:0] psw_q;
    logic [7:0] accRdata_q;
    logic accRbit_q;
    logic sfrExternal_q;
    logic progToBoot_q;
    logic progBootUser_q;
    logic xdataToDataFlash_q;
    logic xdataWriteProgram_q;
    logic xdataWriteData_q;
    logic sysMemWriteOk_q;

    // reset release through two flops
    // asserts at once but releases on a clock edge, so no register sees a runt release
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            rstSync1_q <= 1'b0;
            rstSync2_q <= 1'b0;
        end else begin
            rstSync1_q <= 1'b1;
            rstSync2_q <= rstSync1_q;
        end
    end

    // access class decode
    // the access type, never the address value, tells bit from byte accesses
    wire isDirect = (accType == MMM_ACC_DIRECT);
    wire isIndirect = (accType == MMM_ACC_INDIRECT);
    wire isBit = (accType == MMM_ACC_BIT);
    wire isWreg = (accType == MMM_ACC_WREG);
    wire isPush = (accType == MMM_ACC_PUSH);
    wire isPop = (accType == MMM_ACC_POP);
    wire directSfr = isDirect && (accAddr >= MMM_SFR_BASE);
    wire directRam = isDirect && (accAddr < MMM_SFR_BASE);

    // bit address: below 80h picks RAM 20h-2Fh, above picks SFR with low nibble 0h or 8h
    wire bitInSfr = accAddr[7];
    wire [7:0] bitRamByte = MMM_BIT_RAM_BASE + {4'h0, accAddr[6:3]};
    wire [7:0] bitSfrByte = {accAddr[7:3], 3'b000};
    wire [2:0] bitIdx = accAddr[2:0];

    // working registers, bank base is bank times eight
    wire [1:0] bank = psw_q[MMM_PSW_BANK_HI:MMM_PSW_BANK_LO];
    wire [7:0] wregByte = {3'b000, bank, accAddr[2:0]};

    // stack pre-increment on push, read then decrement on pop
    // the pointer wraps at FFh; overflow into low ram is the programmer's problem
    wire [7:0] spInc = stackPtr_q + 8'h01;
    wire [7:0] spDec = stackPtr_q - 8'h01;

    // sfr byte selected by direct or bit access
    wire sfrSel = directSfr || (isBit && bitInSfr);
    wire [7:0] sfrAddr = isBit ? bitSfrByte : accAddr;
    wire hitSp = sfrSel && (sfrAddr == MMM_ADDR_STACK_PTR);
    wire hitWsel = sfrSel && (sfrAddr == MMM_ADDR_WRITE_SEL);
    wire hitPsw = sfrSel && (sfrAddr == MMM_ADDR_PSW);
    wire hitLocal = hitSp || hitWsel || hitPsw;

    // sfr read mux, unknown addresses read zero
    // writes to sfrs not held here are left to the peripherals via sfrExternal
    wire [7:0] sfrRead = hitSp ? stackPtr_q :
                         hitWsel ? writeSel_q :
                         hitPsw ? psw_q : 8'h00;

    // ram byte index for every ram-reaching access
    // stack and pointer accesses share the indirect path into the upper half
    wire ramSel = directRam || isIndirect || isWreg || isPush || isPop || (isBit && !bitInSfr);
    wire [7:0] ramIdx = isWreg ? wregByte :
                        isPush ? spInc :
                        isPop ? stackPtr_q :
                        isBit ? bitRamByte : accAddr;
    wire [7:0] ramByte = ram_q[ramIdx];
    wire ramWr = ramSel && (accWrite || isPush) && !isPop;

    // bit write merge, applies to ram or local sfr
    wire [7:0] bitSrc = bitInSfr ? sfrRead : ramByte;
    logic [7:0] bitMerged;
    always_comb begin
        bitMerged = bitSrc;
        bitMerged[bitIdx] = accBitVal;
    end
    wire [7:0] wrByte = isBit ? bitMerged : accWdata;

    // stack pointer next value: software write, push, pop
    always_comb begin
        stackPtr_d = stackPtr_q;
        if (isPush) begin
            stackPtr_d = spInc;
        end else if (isPop) begin
            stackPtr_d = spDec;
        end else if (hitSp && accWrite) begin
            stackPtr_d = wrByte;
        end
    end

    // core sfrs
    always_ff @(posedge clk or negedge rstSync2_q) begin
        if (!rstSync2_q) begin
            stackPtr_q <= MMM_RST_STACK_PTR;
            writeSel_q <= MMM_RST_WRITE_SEL;
            psw_q <= MMM_RST_PSW;
        end else begin
            stackPtr_q <= stackPtr_d;
            if (hitWsel && accWrite) begin
                writeSel_q <= wrByte;
            end
            if (hitPsw && accWrite) begin
                psw_q <= wrByte;
            end
        end
    end

    // scratchpad storage; no reset, contents undefined at power up
    // skipping the reset saves a wide reset tree; software must initialise what it reads
    always_ff @(posedge clk) begin
        if (ramWr) begin
            ram_q[ramIdx] <= wrByte;
        end
    end

    // program and external data decode
    // the boot window wins over flash whenever the boot rom is enabled
    wire progInBoot = bootRomEn && (progAddr >= MMM_BOOT_BASE);
    wire progInUserBoot = progInBoot && !progModeSerial && (progAddr <= MMM_BOOT_USER_TOP);
    wire xdInFlash = dataFlashPartitioned && (xdataAddr >= MMM_DFLASH_BASE);
    wire wselProg = writeSel_q[MMM_WSEL_BIT];
    wire sysOk = sysMemWrite && progModeSerial
                 && ({24'h0, sysMemAddr} < 32'(MMM_SYSMEM_WR_BYTES));

    // registered answers
    // every answer lands on the taking edge, one cycle after the request, a fixed latency for the core
    always_ff @(posedge clk or negedge rstSync2_q) begin
        if (!rstSync2_q) begin
            accRdata_q <= 8'h00;
            accRbit_q <= 1'b0;
            sfrExternal_q <= 1'b0;
            progToBoot_q <= 1'b0;
            progBootUser_q <= 1'b0;
            xdataToDataFlash_q <= 1'b0;
            xdataWriteProgram_q <= 1'b0;
            xdataWriteData_q <= 1'b0;
            sysMemWriteOk_q <= 1'b0;
        end else begin
            accRdata_q <= sfrSel ? sfrRead : (ramSel ? ramByte : 8'h00);
            accRbit_q <= bitSrc[bitIdx];
            sfrExternal_q <= sfrSel && !hitLocal;
            progToBoot_q <= progInBoot;
            progBootUser_q <= progInUserBoot;
            xdataToDataFlash_q <= xdInFlash;
            xdataWriteProgram_q <= xdataWrite && wselProg;
            xdataWriteData_q <= xdataWrite && !wselProg;
            sysMemWriteOk_q <= sysOk;
        end
    end

    assign accRdata = accRdata_q;
    assign accRbit = accRbit_q;
    assign sfrExternal = sfrExternal_q;
    assign progToBoot = progToBoot_q;
    assign progBootUser = progBootUser_q;
    assign resetVector = MMM_RESET_VECTOR;
    assign xdataToDataFlash = xdataToDataFlash_q;
    assign xdataWriteProgram = xdataWriteProgram_q;
    assign xdataWriteData = xdataWriteData_q;
    assign sysMemWriteOk = sysMemWriteOk_q;
    assign bankSel = bank;
    assign stackPtr = stackPtr_q;

    // stack pointer comes out of reset at its fixed value
    a_sp_reset: assert property (@(posedge clk) $rose(rstSync2_q) |-> stackPtr == MMM_RST_STACK_PTR)
        else $error("stack pointer not 07h after reset");

    // stack steps, built from named one-cycle requests
    sequence s_push;
        isPush;
    endsequence
    sequence s_pop;
        isPop;
    endsequence
    // a pushed byte must come back on a pop issued in the cycle right after the push
    sequence s_push_pop;
        s_push ##1 s_pop;
    endsequence
    a_push_incr: assert property (@(posedge clk) disable iff (!rstSync2_q)
        s_push |=> stackPtr == $past(stackPtr) + 8'h01)
        else $error("push did not pre-increment stack pointer");
    a_pop_decr: assert property (@(posedge clk) disable iff (!rstSync2_q)
        s_pop |=> stackPtr == $past(stackPtr) - 8'h01)
        else $error("pop did not decrement stack pointer");
    a_push_store: assert property (@(posedge clk) disable iff (!rstSync2_q)
        s_push_pop |=> accRdata == $past(accWdata, 2))
        else $error("pushed value not read back by pop");
    a_sp_write: assert property (@(posedge clk) disable iff (!rstSync2_q)
        (hitSp && accWrite) |=> stackPtr == $past(wrByte))
        else $error("software write to stack pointer lost");
    // without a stack access or a write the pointer must not drift
    a_sp_hold: assert property (@(posedge clk) disable iff (!rstSync2_q)
        (!isPush && !isPop && !(hitSp && accWrite)) |=> $stable(stackPtr))
        else $error("stack pointer moved without a stack access");

    // direct map: upper half is sfr space, lower half is ram
    a_direct_sfr: assert property (@(posedge clk) disable iff (!rstSync2_q)
        (isDirect && accAddr >= MMM_SFR_BASE) |-> sfrSel && !ramWr)
        else $error("direct upper address reached ram");
    a_direct_ram: assert property (@(posedge clk) disable iff (!rstSync2_q)
        (isDirect && accAddr < MMM_SFR_BASE) |-> ramSel && ramIdx == accAddr)
        else $error("direct lower address missed ram");
    // only pointer-style accesses may touch the upper ram half
    a_upper_indirect: assert property (@(posedge clk) disable iff (!rstSync2_q)
        (ramSel && ramIdx[7]) |-> (isIndirect || isPush || isPop))
        else $error("upper ram reached without indirection");
    a_undef_zero: assert property (@(posedge clk) disable iff (!rstSync2_q)
        (directSfr && !hitLocal) |=> accRdata == 8'h00)
        else $error("undefined sfr did not read zero");

    // bit space: ram bytes 20h-2Fh below 80h, sfr bytes ending in 0h or 8h above
    a_bit_ram_range: assert property (@(posedge clk) disable iff (!rstSync2_q)
        (isBit && !accAddr[7]) |-> ramSel && ramIdx >= MMM_BIT_RAM_BASE && ramIdx <= MMM_BIT_RAM_TOP)
        else $error("ram bit outside bit-addressable bytes");
    a_bit_sfr_byte: assert property (@(posedge clk) disable iff (!rstSync2_q)
        (isBit && accAddr[7]) |-> sfrSel && (sfrAddr[3:0] == 4'h0 || sfrAddr[3:0] == 4'h8))
        else $error("sfr bit outside bit-addressable registers");
    // an sfr bit write may change only the addressed bit of its byte
    a_bit_only: assert property (@(posedge clk) disable iff (!rstSync2_q)
        (isBit && bitInSfr) |-> ((wrByte ^ sfrRead) & ~(8'h01 << bitIdx)) == 8'h00)
        else $error("bit write disturbed neighbouring bits");
    a_byte_whole: assert property (@(posedge clk) disable iff (!rstSync2_q)
        (isDirect || isIndirect || isWreg) |-> wrByte == accWdata)
        else $error("byte access merged as a bit access");

    // working register bank follows the status word
    a_bank_base: assert property (@(posedge clk) disable iff (!rstSync2_q)
        isWreg |-> ramIdx == (8'(bankSel) << 3) + 8'(accAddr[2:0]))
        else $error("working register bank address wrong");
    a_psw_write: assert property (@(posedge clk) disable iff (!rstSync2_q)
        (hitPsw && accWrite) |=> bankSel == $past(wrByte[MMM_PSW_BANK_HI:MMM_PSW_BANK_LO]))
        else $error("status word write did not move the bank");

    // program space decode
    a_boot_map: assert property (@(posedge clk) disable iff (!rstSync2_q)
        (bootRomEn && progAddr >= MMM_BOOT_BASE) |=> progToBoot)
        else $error("boot window not decoded");
    a_boot_off: assert property (@(posedge clk) disable iff (!rstSync2_q)
        !bootRomEn |=> !progToBoot && !progBootUser)
        else $error("boot decoded while disabled");
    a_user_boot: assert property (@(posedge clk) disable iff (!rstSync2_q)
        (bootRomEn && !progModeSerial && progAddr >= MMM_BOOT_BASE
         && progAddr <= MMM_BOOT_USER_TOP) |=> progBootUser)
        else $error("user-mode boot routines not decoded");

    // external data and system memory gates
    a_xdata_base: assert property (@(posedge clk) disable iff (!rstSync2_q)
        (xdataAddr < MMM_DFLASH_BASE) |=> !xdataToDataFlash)
        else $error("data flash decoded below base");
    a_xdata_flash: assert property (@(posedge clk) disable iff (!rstSync2_q)
        (dataFlashPartitioned && xdataAddr >= MMM_DFLASH_BASE) |=> xdataToDataFlash)
        else $error("partitioned data flash not decoded");
    a_wsel_route: assert property (@(posedge clk) disable iff (!rstSync2_q)
        xdataWrite |=> (xdataWriteProgram != xdataWriteData))
        else $error("flash write target not unique");
    a_wsel_write: assert property (@(posedge clk) disable iff (!rstSync2_q)
        (hitWsel && accWrite) |=> writeSel_q == $past(wrByte))
        else $error("write select register write lost");
    a_wdata_route: assert property (@(posedge clk) disable iff (!rstSync2_q)
        (xdataWrite && !writeSel_q[MMM_WSEL_BIT]) |=> xdataWriteData)
        else $error("data flash write not routed to data memory");
    a_sysmem_gate: assert property (@(posedge clk) disable iff (!rstSync2_q)
        (!progModeSerial || {24'h0, sysMemAddr} >= 32'(MMM_SYSMEM_WR_BYTES)) |=> !sysMemWriteOk)
        else $error("system memory write allowed outside gate");
    a_sysmem_ok: assert property (@(posedge clk) disable iff (!rstSync2_q)
        (sysMemWrite && progModeSerial && {24'h0, sysMemAddr} < 32'(MMM_SYSMEM_WR_BYTES)) |=> sysMemWriteOk)
        else $error("system memory write refused inside gate");
endmodule : mmm_memory_map

// ==== design/mmm_pkg.sv ====
// Purpose: constants for the on-chip memory map block
// Assumes: 8-bit data, 16-bit program and external data addresses
// Notes: offsets are register-space addresses
package mmm_pkg;
    localparam logic [7:0] MMM_ADDR_STACK_PTR = 8'h81;
    localparam logic [7:0] MMM_ADDR_WRITE_SEL = 8'h8F;
    localparam logic [7:0] MMM_ADDR_PSW = 8'hD0;
    localparam logic [7:0] MMM_RST_STACK_PTR = 8'h07;
    localparam logic [7:0] MMM_RST_WRITE_SEL = 8'h00;
    localparam logic [7:0] MMM_RST_PSW = 8'h00;
    localparam logic [7:0] MMM_SFR_BASE = 8'h80;
    localparam logic [7:0] MMM_BIT_RAM_BASE = 8'h20;
    localparam logic [7:0] MMM_BIT_RAM_TOP = 8'h2F;
    localparam logic [15:0] MMM_RESET_VECTOR = 16'h0000;
    localparam logic [15:0] MMM_BOOT_BASE = 16'hF800;
    localparam logic [15:0] MMM_BOOT_USER_TOP = 16'hFBFF;
    localparam logic [15:0] MMM_DFLASH_BASE = 16'h0400;
    localparam int MMM_PAGE_BYTES = 64;
    localparam int MMM_SYSMEM_WR_BYTES = 64;
    localparam int MMM_PSW_BANK_LO = 3;
    localparam int MMM_PSW_BANK_HI = 4;
    localparam int MMM_WSEL_BIT = 0;
    // access kinds issued by the core
    typedef enum logic [2:0] {
        MMM_ACC_NONE,
        MMM_ACC_DIRECT,
        MMM_ACC_INDIRECT,
        MMM_ACC_BIT,
        MMM_ACC_WREG,
        MMM_ACC_PUSH,
        MMM_ACC_POP
    } mmm_acc_t;
endpackage : mmm_pkg

// ==== verification/mmm_core_model.sv ====
// Purpose: core-side request model for the memory map block
// Assumes: requests change at the falling edge
// Notes: side() sets decode inputs in the same time step as acc()
`timescale 1ns/1ns
module mmm_core_model (
    // clock
    input wire logic clk,
    // register-space request
    output mmm_pkg::mmm_acc_t accType,
    output logic [7:0] accAddr,
    output logic accWrite,
    output logic [7:0] accWdata,
    output logic accBitVal,
    // program, external data and system memory requests
    output logic [15:0] progAddr,
    output logic bootRomEn,
    output logic progModeSerial,
    output logic [15:0] xdataAddr,
    output logic xdataWrite,
    output logic dataFlashPartitioned,
    output logic [7:0] sysMemAddr,
    output logic sysMemWrite
);
    import mmm_pkg::*;
    // one request a cycle; it stands until the next call replaces it
    task automatic acc(input mmm_acc_t t, input logic [7:0] a, input logic w, input logic [7:0] d, input logic b);
        @(negedge clk);
        accType = t;
        accAddr = a;
        accWrite = w;
        accWdata = d;
        accBitVal = b;
    endtask : acc
    // xdata writes only ever name pages taken as erased
    task automatic side(input logic [15:0] pa, input logic be, input logic ps, input logic [15:0] xa,
                        input logic xw, input logic dp, input logic [7:0] sa, input logic sw);
        progAddr = pa;
        bootRomEn = be;
        progModeSerial = ps;
        xdataAddr = xa;
        xdataWrite = xw;
        dataFlashPartitioned = dp;
        sysMemAddr = sa;
        sysMemWrite = sw;
    endtask : side
    // idle at time zero so no input floats before reset ends
    initial begin
        side(16'h0000, 1'b0, 1'b0, 16'h0000, 1'b0, 1'b0, 8'h00, 1'b0);
        accType = MMM_ACC_NONE;
        {accAddr, accWrite, accWdata, accBitVal} = 18'h00000;
    end
endmodule : mmm_core_model

// ==== verification/testbench.sv ====
// Purpose: self-checking bench for the memory map block
// Assumes: results stand from the taking edge and are checked at the next falling edge
// Notes: driver queues notes; a falling-edge watcher compares them
`timescale 1ns/1ns
module testbench;
    import mmm_pkg::*;
    typedef struct {int c; int k; logic [15:0] v;} mmm_note_t;
    localparam logic [15:0] PTAB [4] = '{16'hF7FF, 16'hF800, 16'hFBFF, 16'hFC00};
    localparam logic [15:0] XTAB [4] = '{16'h03FF, 16'h0400, 16'h0000, 16'hFFFF};
    localparam logic [7:0] STAB [4] = '{8'h3F, 8'h40, 8'h00, 8'hFF};
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    mmm_acc_t accType;
    logic accWrite, accBitVal, bootRomEn, progModeSerial, xdataWrite, dataFlashPartitioned, sysMemWrite;
    logic accRbit, sfrExternal, progToBoot, progBootUser, xdataToDataFlash, xdataWriteProgram;
    logic xdataWriteData, sysMemWriteOk;
    logic [7:0] accAddr, accWdata, accRdata, sysMemAddr, stackPtr;
    logic [15:0] progAddr, xdataAddr, resetVector, lfsrQ = 16'h972E;
    logic [1:0] bankSel;
    wire logic [11:0] flagVec = {sysMemWriteOk, xdataWriteData, xdataWriteProgram, xdataToDataFlash, 1'b0,
                                 progBootUser, progToBoot, 2'b00, sfrExternal, accRbit, 1'b0};
    mmm_note_t notes [$];
    int failures = 0;
    int compares = 0;
    int cyc = 0;
    mmm_memory_map mmm_memory_map_i (.clk(clk), .rst_b(rst_b), .accType(accType), .accAddr(accAddr),
        .accWrite(accWrite), .accWdata(accWdata), .accBitVal(accBitVal), .accRdata(accRdata), .accRbit(accRbit),
        .sfrExternal(sfrExternal), .progAddr(progAddr), .bootRomEn(bootRomEn), .progModeSerial(progModeSerial),
        .progToBoot(progToBoot), .progBootUser(progBootUser), .resetVector(resetVector), .xdataAddr(xdataAddr),
        .xdataWrite(xdataWrite), .dataFlashPartitioned(dataFlashPartitioned), .xdataToDataFlash(xdataToDataFlash),
        .xdataWriteProgram(xdataWriteProgram), .xdataWriteData(xdataWriteData), .sysMemAddr(sysMemAddr),
        .sysMemWrite(sysMemWrite), .sysMemWriteOk(sysMemWriteOk), .bankSel(bankSel), .stackPtr(stackPtr));
    mmm_core_model mmm_core_model_i (.clk(clk), .accType(accType), .accAddr(accAddr), .accWrite(accWrite),
        .accWdata(accWdata), .accBitVal(accBitVal), .progAddr(progAddr), .bootRomEn(bootRomEn),
        .progModeSerial(progModeSerial), .xdataAddr(xdataAddr), .xdataWrite(xdataWrite),
        .dataFlashPartitioned(dataFlashPartitioned), .sysMemAddr(sysMemAddr), .sysMemWrite(sysMemWrite));
    function automatic logic [15:0] rnd();
        lfsrQ = {lfsrQ[14:0], lfsrQ[15] ^ lfsrQ[13] ^ lfsrQ[12] ^ lfsrQ[10]};
        return lfsrQ;
    endfunction : rnd
    task automatic req(input mmm_acc_t t, input logic [7:0] a, input logic w, input logic [7:0] d, input logic b);
        mmm_core_model_i.acc(t, a, w, d, b);
    endtask : req
    // note due at the next falling edge, after the taking edge
    task automatic exp(input int k, input logic [15:0] v);
        notes.push_back('{cyc + 1, k, v});
    endtask : exp
    task automatic cmp_word(input logic [15:0] e, input logic [15:0] o);
        compares++;
        if (o !== e) begin
            failures++;
            $display("mismatch at %0t: expected %h got %h", $time, e, o);
        end
    endtask : cmp_word
    task automatic cmp_flag(input logic e, input logic o);
        compares++;
        if (o !== e) begin
            failures++;
            $display("mismatch at %0t: expected %h got %h", $time, e, o);
        end
    endtask : cmp_flag
    task automatic finish_test();
        if (notes.size() > 0) begin
            failures++;
        end
        $display("compares %0d failures %0d", compares, failures);
        if (failures == 0 && compares > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : finish_test
    initial begin
        forever #5 clk = ~clk;
    end
    always @(posedge clk) cyc <= cyc + 1;
    // watcher: kinds 0, 3, 4 and 7 are words, every other kind is a flag
    always @(negedge clk) begin
        while (notes.size() > 0 && notes[0].c == cyc) begin
            case (notes[0].k)
                0: cmp_word(notes[0].v, {8'h00, accRdata});
                3: cmp_word(notes[0].v, {8'h00, stackPtr});
                4: cmp_word(notes[0].v, {14'h0000, bankSel});
                7: cmp_word(notes[0].v, resetVector);
                default: cmp_flag(notes[0].v[0], flagVec[notes[0].k]);
            endcase
            void'(notes.pop_front());
        end
    end
    // hang guard: the whole run is under a hundred cycles
    initial begin
        #50000;
        failures++;
        finish_test();
    end
    initial begin
        logic [7:0] a, d, sa;
        logic [15:0] r, pa, xa;
        repeat (3) @(posedge clk);
        @(negedge clk);
        rst_b = 1'b1;
        repeat (3) @(negedge clk);
        req(MMM_ACC_NONE, 8'h00, 1'b0, 8'h00, 1'b0);
        exp(3, 16'h0007);
        exp(7, 16'h0000);
        for (int i = 0; i < 8; i++) begin
            r = rnd();
            a = {1'b0, r[6:0]};
            req(MMM_ACC_DIRECT, a, 1'b1, r[15:8], 1'b0);
            req(MMM_ACC_DIRECT, a, 1'b0, 8'h00, 1'b0);
            exp(0, {8'h00, r[15:8]});
            exp(2, 16'h0000);
        end
        req(MMM_ACC_INDIRECT, 8'h90, 1'b1, 8'hA5, 1'b0);
        req(MMM_ACC_DIRECT, 8'h90, 1'b0, 8'h00, 1'b0);
        exp(0, 16'h0000);
        exp(2, 16'h0001);
        req(MMM_ACC_INDIRECT, 8'h90, 1'b0, 8'h00, 1'b0);
        exp(0, 16'h00A5);
        // lowest and highest bit of the bit-addressable bytes
        for (int i = 0; i < 2; i++) begin
            d = (i == 0) ? 8'h00 : 8'h7F;
            a = MMM_BIT_RAM_BASE + {3'b000, d[7:3]};
            req(MMM_ACC_DIRECT, a, 1'b1, 8'h00, 1'b0);
            req(MMM_ACC_BIT, d, 1'b1, 8'h00, 1'b1);
            req(MMM_ACC_DIRECT, a, 1'b0, 8'h00, 1'b0);
            exp(0, 16'h0001 << d[2:0]);
            req(MMM_ACC_BIT, d, 1'b0, 8'h00, 1'b0);
            exp(1, 16'h0001);
        end
        req(MMM_ACC_BIT, 8'hD3, 1'b1, 8'h00, 1'b1);
        exp(4, 16'h0001);
        req(MMM_ACC_DIRECT, MMM_ADDR_PSW, 1'b1, 8'h18, 1'b0);
        exp(4, 16'h0003);
        req(MMM_ACC_BIT, 8'hD4, 1'b0, 8'h00, 1'b0);
        exp(1, 16'h0001);
        req(MMM_ACC_BIT, 8'h8B, 1'b0, 8'h00, 1'b0);
        exp(2, 16'h0001);
        r = rnd();
        req(MMM_ACC_WREG, 8'h02, 1'b1, r[7:0], 1'b0);
        req(MMM_ACC_DIRECT, 8'h1A, 1'b0, 8'h00, 1'b0);
        exp(0, {8'h00, r[7:0]});
        req(MMM_ACC_DIRECT, MMM_ADDR_STACK_PTR, 1'b1, 8'h30, 1'b0);
        exp(3, 16'h0030);
        req(MMM_ACC_PUSH, 8'h00, 1'b1, 8'h34, 1'b0);
        exp(3, 16'h0031);
        req(MMM_ACC_PUSH, 8'h00, 1'b1, 8'h12, 1'b0);
        exp(3, 16'h0032);
        req(MMM_ACC_DIRECT, 8'h32, 1'b0, 8'h00, 1'b0);
        exp(0, 16'h0012);
        req(MMM_ACC_POP, 8'h00, 1'b0, 8'h00, 1'b0);
        exp(0, 16'h0012);
        exp(3, 16'h0031);
        req(MMM_ACC_POP, 8'h00, 1'b0, 8'h00, 1'b0);
        exp(0, 16'h0034);
        exp(3, 16'h0030);
        // reset again in mid-run with the stack moved and bank 3 selected
        req(MMM_ACC_NONE, 8'h00, 1'b0, 8'h00, 1'b0);
        @(negedge clk);
        rst_b = 1'b0;
        repeat (2) @(negedge clk);
        rst_b = 1'b1;
        repeat (3) @(negedge clk);
        exp(3, 16'h0007);
        exp(4, 16'h0000);
        exp(7, 16'h0000);
        // write select first picks program flash, then data flash
        for (int j = 0; j < 2; j++) begin
            req(MMM_ACC_DIRECT, MMM_ADDR_WRITE_SEL, 1'b1, {7'h00, j == 0}, 1'b0);
            for (int i = 0; i < 16; i++) begin
                r = rnd();
                pa = PTAB[r[1:0]];
                xa = XTAB[r[3:2]];
                sa = STAB[r[5:4]];
                req(MMM_ACC_NONE, 8'h00, 1'b0, 8'h00, 1'b0);
                mmm_core_model_i.side(pa, r[6], r[7], xa, r[8], r[9], sa, r[10]);
                exp(5, pa >= MMM_BOOT_BASE && r[6]);
                exp(6, pa >= MMM_BOOT_BASE && pa <= MMM_BOOT_USER_TOP && r[6] && !r[7]);
                exp(8, r[9] && xa >= MMM_DFLASH_BASE);
                exp(9, r[8] && j == 0);
                exp(10, r[8] && j == 1);
                exp(11, r[10] && r[7] && sa < MMM_SYSMEM_WR_BYTES);
            end
        end
        repeat (2) @(negedge clk);
        finish_test();
    end
endmodule : testbench
